// ---- logic/smb_dev.sv ----
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - write: addr+w, index, data, acks, stop
// - read: index write, restart, addr+r, byte, nack
// - every byte travels msb first
// - other forms or addresses: silence, back idle
// - malformed transactions leave registers unchanged, except a write with extra data bytes: the first byte still commits at stop
// - answer only the strapped target address
// - never answer the general call address
// - clock low past 25ms aborts, resets engine
// - never hold clock low, tolerate stretching
// - start then stop resets the engine
// - no alert output, ignore alert address
// - strap mode selects port, disables loader
// - attach only after load completes, no limit
// - target only, two transaction types
// - exactly one data byte per transaction
// - current byte in 2mA units, default 50
// - power-on time byte in 2ms steps
// - bit 0 of reg 0 attaches, sleeps port
// - bit 1 of reg 0 locks 01h-10h, once
module smb_dev
  import smb_pkg::*;
#(
  parameter int         TO_CYC  = TIMEOUT_CYC,
  parameter logic [7:0] PON_RST = PON_RST_DEF
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // two-wire link
  smb_if.dev              bus,
  // straps
  input  wire logic [6:0] target_addr_strap,
  input  wire logic       config_select_hi,
  input  wire logic       config_select_lo,
  // hub side
  output logic            smbus_mode,
  output logic            eeprom_loader_en,
  output logic            usb_attach,
  output logic            config_lock,
  output logic [7:0]      ctrl_current_bus_pwr,
  output logic [7:0]      port_power_on_time
);
  localparam int TOW = $clog2(TO_CYC + 1);

  // ---------------------------------------------------------------
  // synchronisers and bus events
  // ---------------------------------------------------------------
  logic       scl_s;
  logic       sda_s;
  logic       scl_p_q;
  logic       sda_p_q;
  logic [6:0] strap_s;
  logic [1:0] sel_s;

  smb_sync #(.W(2)) u_link_sync (
    .clock (clock),
    .d     ({bus.scl, bus.sda}),
    .q     ({scl_s, sda_s})
  );

  smb_sync #(.W(9)) u_strap_sync (
    .clock (clock),
    .d     ({target_addr_strap, config_select_hi, config_select_lo}),
    .q     ({strap_s, sel_s})
  );

  always_ff @(posedge clock) begin
    scl_p_q <= scl_s;
    sda_p_q <= sda_s;
  end

  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_ev  = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  smb_dev_state_t state_q;
  smb_dev_state_t nxt_q;
  logic [2:0]     cnt_q;
  logic           done_q;
  logic [7:0]     shift_q;
  logic [7:0]     idx_q;
  logic [7:0]     wdat_q;
  logic           oe_q;
  logic [TOW-1:0] to_q;
  logic [6:0]     own_q;
  logic           mode_q;
  logic           loader_q;
  logic           attach_q;
  logic           lock_q;
  logic [7:0]     cfg_q [IDX_CFG_FIRST:IDX_CFG_LAST];

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire [6:0] rx_addr  = shift_q[7:1];
  wire       rx_rw    = shift_q[0];
  wire       addr_ok  = (rx_addr == own_q) && (rx_addr != GEN_CALL)
                      && (rx_addr != ALERT_ADDR);
  wire       active   = mode_q & ~attach_q;
  wire       to_hit   = (to_q == TOW'(TO_CYC - 1));
  wire       rep_st   = (state_q == S_DATA) && (cnt_q == RX_ONE_BIT)
                      && !done_q;
  wire       idx_cfg  = (idx_q >= IDX_CFG_FIRST) && (idx_q <= IDX_CFG_LAST);
  wire       commit   = stop_ev && (state_q == S_STOPW);
  wire       cmd_wr   = commit && (idx_q == IDX_CMD);
  wire       srst     = cmd_wr && wdat_q[BIT_SRST];
  wire       cfg_wr   = commit && idx_cfg && !lock_q;
  wire [7:0] cmd_rd   = (8'(lock_q) << BIT_LOCK)
                      | (8'(attach_q) << BIT_ATTACH);
  wire [7:0] rd_data  = (idx_q == IDX_CMD) ? cmd_rd
                      : idx_cfg ? cfg_q[idx_q] : 8'h00;
  wire       byte_ack = (state_q == S_ADDR)  ? addr_ok && rx_rw == RW_WRITE
                      : (state_q == S_RADDR) ? addr_ok && rx_rw == RW_READ
                      : 1'b1;
  smb_dev_state_t after;
  assign after = (state_q == S_ADDR)  ? S_INDEX
               : (state_q == S_INDEX) ? S_DATA
               : (state_q == S_DATA)  ? S_STOPW
               : S_TX;

  // ---------------------------------------------------------------
  // straps and mode
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      own_q    <= strap_s;
      mode_q   <= (sel_s == SMBUS_MODE_SEL);
      loader_q <= (sel_s != SMBUS_MODE_SEL);
    end
  end

  // ---------------------------------------------------------------
  // clock-low time-out
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset || scl_s || state_q == S_IDLE || to_hit) begin
      to_q <= '0;
    end else begin
      to_q <= TOW'(to_q + 1'b1);
    end
  end

  // ---------------------------------------------------------------
  // serial engine
  // ---------------------------------------------------------------
  // the engine only ever pulls data low; clock is never driven
  always_ff @(posedge clock) begin
    if (reset || !active || stop_ev || to_hit) begin
      state_q <= S_IDLE;
      oe_q    <= 1'b0;
      done_q  <= 1'b0;
      cnt_q   <= '0;
    end else if (start_ev) begin
      state_q <= rep_st ? S_RADDR : S_ADDR;
      oe_q    <= 1'b0;
      done_q  <= 1'b0;
      cnt_q   <= '0;
    end else begin
      case (state_q)
        S_ADDR, S_INDEX, S_DATA, S_RADDR: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_s};
            cnt_q   <= 3'(cnt_q + 1'b1);
            done_q  <= (cnt_q == LAST_BIT);
          end else if (scl_fall && done_q) begin
            done_q <= 1'b0;
            if (state_q == S_INDEX) idx_q <= shift_q;
            if (state_q == S_DATA) wdat_q <= shift_q;
            if (byte_ack) begin
              oe_q    <= 1'b1;
              state_q <= S_ACK;
              nxt_q   <= after;
            end else begin
              state_q <= S_IGNORE;
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            cnt_q   <= '0;
            state_q <= nxt_q;
            if (nxt_q == S_TX) begin
              shift_q <= rd_data;
              oe_q    <= ~rd_data[7];
            end else begin
              oe_q <= 1'b0;
            end
          end
        end
        S_TX: begin
          if (scl_fall) begin
            if (cnt_q == LAST_BIT) begin
              oe_q    <= 1'b0;
              state_q <= S_IGNORE;
            end else begin
              oe_q    <= ~shift_q[6];
              shift_q <= {shift_q[6:0], 1'b0};
              cnt_q   <= 3'(cnt_q + 1'b1);
            end
          end
        end
        S_IDLE, S_STOPW, S_IGNORE: begin
          oe_q <= 1'b0;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  function automatic logic [7:0] cfg_rst(input int i);
    cfg_rst = (i == int'(IDX_CUR)) ? CUR_RST
            : (i == int'(IDX_PON)) ? PON_RST : 8'h00;
  endfunction

  always_ff @(posedge clock) begin
    if (reset) begin
      attach_q <= 1'b0;
      lock_q   <= 1'b0;
    end else if (cmd_wr) begin
      attach_q <= attach_q | wdat_q[BIT_ATTACH];
      lock_q   <= lock_q | wdat_q[BIT_LOCK];
    end
  end

  always_ff @(posedge clock) begin
    for (int i = int'(IDX_CFG_FIRST); i <= int'(IDX_CFG_LAST); i++) begin
      if (reset || srst) begin
        cfg_q[i] <= cfg_rst(i);
      end else if (cfg_wr && idx_q == 8'(i)) begin
        cfg_q[i] <= wdat_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign bus.dev_sda_o          = 1'b0;
  assign bus.dev_sda_oe         = oe_q;
  assign smbus_mode             = mode_q;
  assign eeprom_loader_en       = loader_q;
  assign usb_attach             = attach_q;
  assign config_lock            = lock_q;
  assign ctrl_current_bus_pwr   = cfg_q[IDX_CUR];
  assign port_power_on_time     = cfg_q[IDX_PON];
endmodule

`default_nettype wire

// ---- logic/smb_host.sv ----
`timescale 1ns/1ps
`default_nettype none

module smb_host
  import smb_pkg::*;
#(
  parameter int QTR = QTR_CYC
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // two-wire link
  smb_if.host             bus,
  // command port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata
);
  localparam int QW = $clog2(QTR + 1);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  smb_host_state_t state_q;
  logic [QW-1:0]   qc_q;
  logic [1:0]      ph_q;
  logic [1:0]      seg_q;
  logic [3:0]      bit_q;
  logic [7:0]      sh_q;
  logic [6:0]      target_q;
  logic [7:0]      index_q;
  logic [7:0]      wdata_q;
  logic [7:0]      rdata_q;
  logic            read_q;
  logic            busy_q;
  logic            done_q;
  logic            nack_q;
  logic            scl_oe_q;
  logic            sda_oe_q;
  logic            sda_s;

  smb_sync #(.W(1)) u_sda_sync (
    .clock (clock),
    .d     (bus.sda),
    .q     (sda_s)
  );

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire       go       = reg_wr && (reg_addr == HREG_CTRL)
                      && reg_wdata[CTRL_GO] && !busy_q;
  wire       tick     = (qc_q == QW'(QTR - 1));
  wire       rx_seg   = read_q && (seg_q == SEG_RX);
  wire       last_seg = (seg_q == (read_q ? SEG_RX : SEG_THIRD));
  wire       ack_slot = (bit_q == ACK_BIT);
  wire [7:0] tx_byte  = (seg_q == SEG_ADDR)  ? {target_q, RW_WRITE}
                      : (seg_q == SEG_INDEX) ? index_q
                      : rx_seg ? RX_IDLE_BYTE
                      : read_q ? {target_q, RW_READ} : wdata_q;
  wire [7:0] cur_byte = (bit_q == 4'h0) ? tx_byte : sh_q;
  wire [7:0] status   = (8'(nack_q) << STAT_NACK) | (8'(done_q) << STAT_DONE)
                      | (8'(busy_q) << STAT_BUSY);
  wire [7:0] rd_mux   = (reg_addr == HREG_TARGET) ? {1'b0, target_q}
                      : (reg_addr == HREG_INDEX)  ? index_q
                      : (reg_addr == HREG_WDATA)  ? wdata_q
                      : (reg_addr == HREG_STATUS) ? status
                      : (reg_addr == HREG_RDATA)  ? rdata_q : 8'h00;

  // ---------------------------------------------------------------
  // command registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      target_q  <= '0;
      index_q   <= '0;
      wdata_q   <= '0;
      reg_rdata <= '0;
    end else begin
      if (reg_wr && reg_addr == HREG_TARGET) target_q <= reg_wdata[6:0];
      if (reg_wr && reg_addr == HREG_INDEX) index_q <= reg_wdata;
      if (reg_wr && reg_addr == HREG_WDATA) wdata_q <= reg_wdata;
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // quarter-bit timer
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset || go || tick) qc_q <= '0;
    else qc_q <= QW'(qc_q + 1'b1);
  end

  // ---------------------------------------------------------------
  // bit sequencer: each bit is drive, rise, sample, fall
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q  <= H_IDLE;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      busy_q   <= 1'b0;
      done_q   <= 1'b0;
      nack_q   <= 1'b0;
      read_q   <= 1'b0;
      ph_q     <= PH_DRIVE;
      seg_q    <= SEG_ADDR;
      bit_q    <= '0;
      sh_q     <= '0;
      rdata_q  <= '0;
    end else if (go) begin
      state_q <= H_START;
      busy_q  <= 1'b1;
      done_q  <= 1'b0;
      nack_q  <= 1'b0;
      read_q  <= reg_wdata[CTRL_READ];
      ph_q    <= PH_DRIVE;
      seg_q   <= SEG_ADDR;
      bit_q   <= '0;
    end else if (tick && state_q != H_IDLE) begin
      ph_q <= 2'(ph_q + 1'b1);
      case (state_q)
        H_START: begin
          if (ph_q == PH_DRIVE) sda_oe_q <= 1'b0;
          if (ph_q == PH_RISE) scl_oe_q <= 1'b0;
          if (ph_q == PH_SAMPLE) sda_oe_q <= 1'b1;
          if (ph_q == PH_FALL) begin
            scl_oe_q <= 1'b1;
            state_q  <= H_BIT;
            bit_q    <= '0;
          end
        end
        H_BIT: begin
          if (ph_q == PH_DRIVE) begin
            sh_q     <= cur_byte;
            sda_oe_q <= !ack_slot && !cur_byte[7];
          end
          if (ph_q == PH_RISE) scl_oe_q <= 1'b0;
          if (ph_q == PH_SAMPLE) begin
            if (ack_slot) nack_q <= sda_s && !rx_seg;
            else sh_q <= {sh_q[6:0], sda_s};
          end
          if (ph_q == PH_FALL) begin
            scl_oe_q <= 1'b1;
            if (!ack_slot) begin
              bit_q <= 4'(bit_q + 1'b1);
            end else begin
              bit_q <= '0;
              if (nack_q) begin
                state_q <= H_STOP;
              end else if (read_q && seg_q == SEG_INDEX) begin
                state_q <= H_START;
                seg_q   <= SEG_THIRD;
              end else if (last_seg) begin
                state_q <= H_STOP;
                if (rx_seg) rdata_q <= sh_q;
              end else begin
                seg_q <= 2'(seg_q + 1'b1);
              end
            end
          end
        end
        H_STOP: begin
          if (ph_q == PH_DRIVE) sda_oe_q <= 1'b1;
          if (ph_q == PH_RISE) scl_oe_q <= 1'b0;
          if (ph_q == PH_SAMPLE) sda_oe_q <= 1'b0;
          if (ph_q == PH_FALL) begin
            state_q <= H_IDLE;
            busy_q  <= 1'b0;
            done_q  <= 1'b1;
          end
        end
        default: begin
          state_q <= H_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  assign bus.host_scl_o  = 1'b0;
  assign bus.host_scl_oe = scl_oe_q;
  assign bus.host_sda_o  = 1'b0;
  assign bus.host_sda_oe = sda_oe_q;
endmodule

`default_nettype wire

// ---- logic/smb_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface smb_if;
  logic scl;
  logic sda;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;

  // open-drain: clock driven by the host only, data a wired-and of both parties
  assign scl = host_scl_oe ? host_scl_o : 1'b1;
  assign sda = (host_sda_oe ? host_sda_o : 1'b1)
             & (dev_sda_oe ? dev_sda_o : 1'b1);

  modport dev (
    input  scl,
    input  sda,
    output dev_sda_o,
    output dev_sda_oe
  );

  modport host (
    input  scl,
    input  sda,
    output host_scl_o,
    output host_scl_oe,
    output host_sda_o,
    output host_sda_oe
  );
endinterface

`default_nettype wire

// ---- logic/smb_pkg.sv ----
package smb_pkg;

  // ---------------------------------------------------------------
  // clocking and timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ      = 50_000_000;
  localparam int TIMEOUT_MS  = 25;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int SCL_HZ      = 100_000;
  localparam int QTR_CYC     = CLK_HZ / (4 * SCL_HZ);

  // ---------------------------------------------------------------
  // device register map
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_CMD       = 8'h00;
  localparam logic [7:0] IDX_CFG_FIRST = 8'h01;
  localparam logic [7:0] IDX_CFG_LAST  = 8'h10;
  localparam logic [7:0] IDX_CUR       = 8'h0e;
  localparam logic [7:0] IDX_PON       = 8'h0f;
  localparam logic [7:0] CUR_RST       = 8'h32;
  localparam logic [7:0] PON_RST_DEF   = 8'h00;
  localparam int         BIT_ATTACH    = 0;
  localparam int         BIT_LOCK      = 1;
  localparam int         BIT_SRST      = 2;

  // ---------------------------------------------------------------
  // link encoding
  // ---------------------------------------------------------------
  localparam logic [6:0] GEN_CALL       = 7'h00;
  localparam logic [6:0] ALERT_ADDR     = 7'h0c;
  localparam logic [1:0] SMBUS_MODE_SEL = 2'h1;
  localparam logic       RW_WRITE       = 1'b0;
  localparam logic       RW_READ        = 1'b1;
  localparam logic [2:0] RX_ONE_BIT     = 3'h1;
  localparam logic [2:0] LAST_BIT       = 3'h7;
  localparam logic [3:0] ACK_BIT        = 4'h8;
  localparam logic [7:0] RX_IDLE_BYTE   = 8'hff;

  // ---------------------------------------------------------------
  // host command registers
  // ---------------------------------------------------------------
  localparam logic [7:0] HREG_CTRL   = 8'h00;
  localparam logic [7:0] HREG_TARGET = 8'h01;
  localparam logic [7:0] HREG_INDEX  = 8'h02;
  localparam logic [7:0] HREG_WDATA  = 8'h03;
  localparam logic [7:0] HREG_STATUS = 8'h04;
  localparam logic [7:0] HREG_RDATA  = 8'h05;
  localparam int         CTRL_GO     = 0;
  localparam int         CTRL_READ   = 1;
  localparam int         STAT_BUSY   = 0;
  localparam int         STAT_DONE   = 1;
  localparam int         STAT_NACK   = 2;
  localparam logic [1:0] SEG_ADDR    = 2'h0;
  localparam logic [1:0] SEG_INDEX   = 2'h1;
  localparam logic [1:0] SEG_THIRD   = 2'h2;
  localparam logic [1:0] SEG_RX      = 2'h3;
  localparam logic [1:0] PH_DRIVE    = 2'h0;
  localparam logic [1:0] PH_RISE     = 2'h1;
  localparam logic [1:0] PH_SAMPLE   = 2'h2;
  localparam logic [1:0] PH_FALL     = 2'h3;

  // ---------------------------------------------------------------
  // state machines
  // ---------------------------------------------------------------
  typedef enum logic [8:0] {
    S_IDLE   = 9'h001,
    S_ADDR   = 9'h002,
    S_INDEX  = 9'h004,
    S_DATA   = 9'h008,
    S_RADDR  = 9'h010,
    S_ACK    = 9'h020,
    S_TX     = 9'h040,
    S_STOPW  = 9'h080,
    S_IGNORE = 9'h100
  } smb_dev_state_t;

  typedef enum logic [3:0] {
    H_IDLE  = 4'h1,
    H_START = 4'h2,
    H_BIT   = 4'h4,
    H_STOP  = 4'h8
  } smb_host_state_t;

endpackage

// ---- logic/smb_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module smb_sync #(
  parameter int W = 1
) (
  // clock
  input  wire logic         clock,
  // asynchronous input and synchronised copy
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clock) begin
    meta_q <= d;
    q      <= meta_q;
  end
endmodule

`default_nettype wire

// ---- tb/smb_sva.sv ----
`timescale 1ns/1ps
`default_nettype none

module smb_sva
  import smb_pkg::*;
#(
  parameter logic [6:0] ADDR = 7'h2c
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // link
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe
);
  // ----------------------------
  // link framing tracker
  // ----------------------------
  logic       scl_q, sda_q, fr, rs;
  logic [3:0] nb;
  logic [2:0] nby;
  logic [7:0] sh;
  wire        st   = scl && scl_q && sda_q && !sda;
  wire        sp   = scl && scl_q && !sda_q && sda;
  wire        rise = scl && !scl_q;
  wire        ack0 = rise && nb == 4'h8 && nby == 3'h0;
  wire        ack1 = rise && nb == 4'h8 && nby == 3'h1 && rs;

  always_ff @(posedge clock) begin
    scl_q <= scl;
    sda_q <= sda;
    if (reset) begin
      {fr, rs, nb, nby} <= 9'h000;
    end else if (st) begin
      {fr, rs, nb, nby} <= {1'b1, fr, 7'h00};
    end else if (sp) begin
      {fr, rs} <= 2'h0;
    end else if (rise && nb == 4'h8) begin
      nb  <= 4'h0;
      nby <= nby + 3'h1;
    end else if (rise) begin
      nb <= nb + 4'h1;
      sh <= {sh[6:0], sda};
    end
  end

  // ----------------------------
  // checks
  // ----------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  a_foreign_nack: assert property (ack0 && sh[7:1] != ADDR |-> sda)
    else $error("foreign address acknowledged");
  a_gencall_nack: assert property (ack0 && sh[7:1] == GEN_CALL |-> sda)
    else $error("general call acknowledged");
  a_alert_nack: assert property (ack0 && sh[7:1] == ALERT_ADDR |-> sda)
    else $error("alert address acknowledged");
  a_dev_edge: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device data moved while clock high");
  a_dev_framed: assert property (dev_sda_oe |-> fr)
    else $error("device drove outside a frame");
  a_ack_nine: assert property (scl && scl_q && dev_sda_oe && !rs |-> nb == 4'h0)
    else $error("device drove a host bit");
  a_host_nack: assert property (ack1 |-> sda)
    else $error("read byte not closed by nack");
  a_one_byte: assert property (rise && nb == 4'h8 |-> nby < (rs ? 3'h2 : 3'h3))
    else $error("more than one data byte");

  c_addr_ack: cover property (ack0 && !sda);
  c_restart: cover property (st && fr);
  c_read_end: cover property (ack1);
endmodule

`default_nettype wire

// ---- tb/smbus_config_slave_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module smbus_config_slave_tb
  import smb_pkg::*;
;
  localparam logic [6:0] TGT = 7'h2c;
  logic       clock = 1'b0;
  logic       reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       rd_q = 1'b0;
  logic       sel_lo = 1'b1;
  logic [7:0] reg_rdata, cur, pon, v, rv;
  logic       smode, ldr, att, lck;
  logic [7:0] exp_q[$];
  logic [6:0] bad [3] = '{TGT ^ 7'h01, GEN_CALL, ALERT_ADDR};
  int         err_total = 0;
  int         compares = 0;

  always #10 clock = ~clock;

  smb_if bus ();
  smb_dev #(.TO_CYC(2000)) u_smb_dev (.clock(clock), .reset(reset),
    .bus(bus), .target_addr_strap(TGT), .config_select_hi(1'b0),
    .config_select_lo(sel_lo), .smbus_mode(smode), .eeprom_loader_en(ldr),
    .usb_attach(att), .config_lock(lck), .ctrl_current_bus_pwr(cur),
    .port_power_on_time(pon));
  smb_host #(.QTR(10)) u_smb_host (.clock(clock), .reset(reset),
    .bus(bus), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  smb_sva #(.ADDR(TGT)) u_smb_sva (.clock(clock), .reset(reset),
    .scl(bus.scl), .sda(bus.sda), .dev_sda_oe(bus.dev_sda_oe));

  // ----------------------------
  // helpers
  // ----------------------------
  task automatic stop_test();
    if (err_total == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want) begin
      err_total++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic nt);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    if (nt) begin
      exp_q.push_back(e);
    end
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    rv = reg_rdata;
  endtask

  // one link transaction; a read expects d back
  task automatic xfer(input logic rdn, input logic [6:0] t,
                      input logic [7:0] i, input logic [7:0] d,
                      input logic nk);
    int n;
    wr(HREG_TARGET, {1'b0, t});
    wr(HREG_INDEX, i);
    wr(HREG_WDATA, d);
    wr(HREG_CTRL, {6'h00, rdn, 1'b1});
    n = 0;
    rv = 8'h01;
    while (rv[STAT_BUSY] !== 1'b0) begin
      rd(HREG_STATUS, 8'h00, 1'b0);
      n++;
      if (n > 2000) begin
        err_total++;
        stop_test();
      end
    end
    rd(HREG_STATUS, {5'h00, nk, 2'b10}, 1'b1);
    if (rdn && !nk) begin
      rd(HREG_RDATA, d, 1'b1);
    end
  endtask

  always @(posedge clock) begin
    if (rd_q && exp_q.size() > 0) begin
      chk(reg_rdata, exp_q.pop_front());
    end
    rd_q <= reg_rd;
  end

  // ----------------------------
  // scenarios
  // ----------------------------
  initial begin
    void'($urandom(13));
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    chk(cur, CUR_RST);
    chk(pon, PON_RST_DEF);
    chk({4'h0, smode, ldr, att, lck}, 8'h08);
    foreach (bad[k]) begin
      xfer(RW_WRITE, bad[k], IDX_CUR, 8'h5a, 1'b1);
      chk(cur, CUR_RST);
    end
    v = 8'($urandom());
    xfer(RW_WRITE, TGT, IDX_CUR, v, 1'b0);
    chk(cur, v);
    xfer(RW_READ, TGT, IDX_CUR, v, 1'b0);
    v = 8'($urandom());
    xfer(RW_WRITE, TGT, IDX_PON, v, 1'b0);
    chk(pon, v);
    xfer(RW_WRITE, TGT, 8'h40, 8'hff, 1'b0);
    chk(pon, v);
    xfer(RW_READ, TGT, 8'h40, 8'h00, 1'b0);
    xfer(RW_WRITE, TGT, IDX_CMD, 8'h04, 1'b0);
    chk(cur, CUR_RST);
    chk(pon, PON_RST_DEF);
    xfer(RW_WRITE, TGT, IDX_CMD, 8'h02, 1'b0);
    chk({7'h00, lck}, 8'h01);
    xfer(RW_WRITE, TGT, IDX_CMD, 8'h00, 1'b0);
    chk({7'h00, lck}, 8'h01);
    xfer(RW_READ, TGT, IDX_CMD, 8'h02, 1'b0);
    xfer(RW_WRITE, TGT, IDX_PON, ~PON_RST_DEF, 1'b0);
    chk(pon, PON_RST_DEF);
    chk({7'h00, att}, 8'h00);
    xfer(RW_WRITE, TGT, IDX_CMD, 8'h01, 1'b0);
    chk({7'h00, att}, 8'h01);
    xfer(RW_READ, TGT, IDX_CUR, 8'h00, 1'b1);
    // second reset with the loader straps: port stays silent
    reset  <= 1'b1;
    sel_lo <= 1'b0;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    chk({4'h0, smode, ldr, att, lck}, 8'h04);
    xfer(RW_WRITE, TGT, IDX_CUR, 8'h5a, 1'b1);
    chk(cur, CUR_RST);
    stop_test();
  end
endmodule

`default_nettype wire
